/* hw/ci_pkg.sv */
/*
  Package for the counter-input measurement block: register offsets,
  field positions, reset values and enumerations.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package ci_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_COUNT = 12'h008;
  localparam logic [11:0] OFF_HIGH = 12'h00c;
  localparam logic [11:0] OFF_LOW = 12'h010;
  localparam logic [11:0] OFF_FIFO = 12'h014;

  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FUNC_LSB = 1;   // 2 bits
  localparam int CTRL_CAP_LSB = 3;    // 2 bits
  localparam int CTRL_EDGE_BIT = 5;   // 1 = falling active edge
  localparam int CTRL_SEDGE_BIT = 6;  // 1 = falling sample clock edge, except in averaging mode
  localparam int CTRL_DSRC_BIT = 7;   // 1 = direction from level input
  localparam int CTRL_DIR_BIT = 8;    // software direction, 1 = up
  localparam int CTRL_CLR_BIT = 9;    // write 1: clear buffer and counts, high/low durations excepted

  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

  // status fields
  localparam int ST_EMPTY_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_OVF_BIT = 2;

  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    FUNC_EDGE = 2'h0,
    FUNC_PULSE = 2'h1,
    FUNC_FREQ = 2'h2,
    FUNC_PERIOD = 2'h3
  } func_t;

  typedef enum logic [1:0] {
    CAP_ONE_SHOT = 2'h0,
    CAP_INTERNAL = 2'h1,
    CAP_IMPLICIT = 2'h2
  } cap_t;

endpackage

/* hw/stream_if.sv */
/*
  Valid/ready word stream between the measurement core and its buffer.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // stream_if

/* hw/word_fifo.sv */
/*
  Flip-flop FIFO with valid/ready on both sides; width and depth set
  by parameters. Assumes one clock and an active-low async reset.
*/
`timescale 1ns/10ps
module word_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  stream_if.snk wr,
  stream_if.src rd
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  // honest flags: ready drops when full, valid when empty
  assign wr.ready = (s_r.cnt != (AW + 1)'(D));
  assign rd.valid = (s_r.cnt != '0);
  assign rd.data = s_r.mem[s_r.rp];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // pointer and count update
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = wr.data;
      s_nxt.wp = bump(s_r.wp);
    end
    if (pop) begin
      s_nxt.rp = bump(s_r.rp);
    end
    s_nxt.cnt = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    if (flush) begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // word_fifo

/* hw/counter_input_measurement.sv */
/*
  Counter-input measurement for one 32-bit counter: edge counting,
  pulse, frequency and period measurement, single or buffered capture.
  Assumes terminal inputs and sample clock synchronous to pclk (50 MHz),
  pclk serving as timebase, and an APB master on the register side.
*/
// The APB interface to the registers and the register addresses were chosen for this implementation.
//
// Behaviour
// RL1 - single edge counting updates the count register on each active edge.
// RL2 - buffered edge counting on internal clock pushes count per sample edge.
// RL3 - buffered edge counting on implicit clock pushes count per input edge.
// RL4 - direction comes from software or the level input, high counts up.
// RL5 - single pulse mode writes high or low duration at each input edge.
// RL6 - buffered pulse on internal clock stores duration per sample edge.
// RL7 - buffered pulse on implicit clock stores each duration at its end.
// RL8 - single frequency mode reuses the pulse datapath for high/low ticks.
// RL9 - averaging mode counts full periods and their timebase edges.
// RL10 - averaging mode pushes period count and timebase count as a pair.
// RL11 - host computes frequency as base times periods over timebase edges.
// RL12 - implicit frequency mode buffers high and low ticks per period.
// RL13 - period measurement uses the frequency capture path unchanged.
// RL14 - every count held by the counter is 32 bits wide.
// RL15 - buffered capture uses its own storage, paced by a sample clock.
// RL16 - level durations count timebase edges, restarting at each change.
`timescale 1ns/10ps
module counter_input_measurement
  import ci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic edge_input_terminal,
  input wire logic level_input_terminal,
  input wire logic sample_clock
);

  typedef enum logic [2:0] {
    PUSH_IDLE = 3'b001,
    PUSH_FIRST = 3'b010,
    PUSH_SECOND = 3'b100
  } push_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] count;
    logic [31:0] run_ticks;
    logic [31:0] high_level_tick_count;
    logic [31:0] low_level_tick_count;
    logic [31:0] full_period_count;
    logic [31:0] timebase_edge_count;
    logic [31:0] period_ticks;
    logic [31:0] pend_a;
    logic [31:0] pend_b;
    logic first_rise_seen;
    logic edge_d;
    logic level_d;
    logic samp_d;
    logic overflow;
    push_t push;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  stream_if #(.W(FIFO_WIDTH)) cap_s ();
  stream_if #(.W(FIFO_WIDTH)) out_s ();

  logic wr_acc;
  logic rd_acc;
  logic clr_req;

  word_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(clr_req),
    .wr(cap_s.snk),
    .rd(out_s.src)
  );

  function automatic logic sel_edge(input logic cur, input logic prev,
                                    input logic falling);
    sel_edge = falling ? (prev && !cur) : (!prev && cur);
  endfunction

  // first cycle of the access phase, one cycle before the slave answers
  assign wr_acc = psel && penable && pwrite && !s_r.pready;
  assign rd_acc = psel && penable && !pwrite && !s_r.pready;
  assign clr_req = wr_acc && (paddr == OFF_CTRL) && pwdata[CTRL_CLR_BIT];
  assign cap_s.valid = (s_r.push != PUSH_IDLE);
  assign cap_s.data = (s_r.push == PUSH_SECOND) ? s_r.pend_b : s_r.pend_a;
  assign out_s.ready = rd_acc && (paddr == OFF_FIFO);

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;

  // measurement, capture and register logic
  always_comb begin
    logic en;
    logic falling;
    logic up;
    logic in_edge;
    logic lvl_rise;
    logic lvl_fall;
    logic samp_edge;
    logic samp_rise;
    logic do_push;
    logic pair;
    logic [31:0] a;
    logic [31:0] b;
    func_t fn;
    cap_t cap;
    en = s_r.ctrl[CTRL_EN_BIT];
    falling = s_r.ctrl[CTRL_EDGE_BIT];
    fn = func_t'(s_r.ctrl[CTRL_FUNC_LSB +: 2]);
    cap = cap_t'(s_r.ctrl[CTRL_CAP_LSB +: 2]);
    s_nxt = s_r;
    do_push = 1'b0;
    pair = 1'b0;
    a = s_r.count;
    b = '0;
    s_nxt.edge_d = edge_input_terminal;
    s_nxt.level_d = level_input_terminal;
    s_nxt.samp_d = sample_clock;
    in_edge = sel_edge(edge_input_terminal, s_r.edge_d, falling);
    lvl_rise = sel_edge(level_input_terminal, s_r.level_d, 1'b0);
    lvl_fall = sel_edge(level_input_terminal, s_r.level_d, 1'b1);
    samp_edge = sel_edge(sample_clock, s_r.samp_d,
                         s_r.ctrl[CTRL_SEDGE_BIT]);
    samp_rise = sel_edge(sample_clock, s_r.samp_d, 1'b0);
    up = s_r.ctrl[CTRL_DSRC_BIT] ? level_input_terminal
                                 : s_r.ctrl[CTRL_DIR_BIT]; // see RL4

    if (en) begin
      case (fn)
        FUNC_EDGE: begin
          if (in_edge) begin
            s_nxt.count = up ? s_r.count + 32'h1
                             : s_r.count - 32'h1; // see RL1, RL14
          end
          if (cap == CAP_INTERNAL && samp_edge) begin
            do_push = 1'b1; // see RL2
          end
          if (cap == CAP_IMPLICIT && in_edge) begin
            do_push = 1'b1; // see RL3
            a = s_nxt.count;
          end
        end
        FUNC_PULSE, FUNC_FREQ, FUNC_PERIOD: begin
          // timebase is pclk; restart on every level change
          s_nxt.run_ticks = s_r.run_ticks + 32'h1; // see RL16
          if (lvl_fall) begin
            s_nxt.high_level_tick_count = s_r.run_ticks; // see RL5, RL8
            s_nxt.run_ticks = 32'h1;
          end
          if (lvl_rise) begin
            s_nxt.low_level_tick_count = s_r.run_ticks; // see RL5, RL8
            s_nxt.run_ticks = 32'h1;
          end
          if (fn != FUNC_PULSE && cap == CAP_INTERNAL) begin
            // averaging: whole periods between rising edges, see RL9
            s_nxt.period_ticks = s_r.period_ticks + 32'h1;
            if (lvl_rise) begin
              s_nxt.first_rise_seen = 1'b1;
              s_nxt.period_ticks = 32'h1;
              if (s_r.first_rise_seen) begin
                s_nxt.full_period_count = s_r.full_period_count + 32'h1;
                s_nxt.timebase_edge_count =
                  s_r.timebase_edge_count + s_r.period_ticks;
              end
            end
            if (samp_rise) begin
              do_push = 1'b1; // see RL10, RL13
              pair = 1'b1;
              a = s_nxt.full_period_count;
              b = s_nxt.timebase_edge_count;
              s_nxt.full_period_count = '0;
              s_nxt.timebase_edge_count = '0;
            end
          end else if (cap == CAP_INTERNAL && samp_edge) begin
            do_push = 1'b1; // see RL6
            a = level_input_terminal ? s_r.run_ticks
                                     : s_nxt.high_level_tick_count;
            b = s_nxt.low_level_tick_count;
            pair = (fn != FUNC_PULSE);
          end else if (cap == CAP_IMPLICIT) begin
            if (fn == FUNC_PULSE && (lvl_rise || lvl_fall)) begin
              do_push = 1'b1; // see RL7
              a = s_r.run_ticks;
            end
            if (fn != FUNC_PULSE && lvl_rise) begin
              do_push = 1'b1; // see RL12, RL13
              pair = 1'b1;
              a = s_nxt.high_level_tick_count;
              b = s_r.run_ticks;
            end
          end
        end
        default: begin
          s_nxt.count = s_r.count;
        end
      endcase
    end

    // buffer drains one word a cycle; any push while a single or pair push is pending drops new data
    case (s_r.push)
      PUSH_IDLE: begin
        if (do_push) begin
          s_nxt.pend_a = a; // see RL15
          s_nxt.pend_b = b;
          s_nxt.push = pair ? PUSH_FIRST : PUSH_SECOND;
          if (!pair) begin
            s_nxt.pend_b = a;
          end
        end
      end
      PUSH_FIRST: begin
        if (cap_s.ready) begin
          s_nxt.push = PUSH_SECOND;
        end
        if (do_push) begin
          s_nxt.overflow = 1'b1;
        end
      end
      PUSH_SECOND: begin
        if (cap_s.ready) begin
          s_nxt.push = PUSH_IDLE;
        end
        if (do_push) begin
          s_nxt.overflow = 1'b1;
        end
      end
      default: begin
        s_nxt.push = PUSH_IDLE;
      end
    endcase
    if (s_r.push != PUSH_IDLE && !cap_s.ready && !pair && do_push) begin
      s_nxt.overflow = 1'b1;
    end

    // apb slave: answers one cycle after the access phase starts
    s_nxt.pready = psel && penable && !s_r.pready;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = '0;
    if (wr_acc) begin
      case (paddr)
        OFF_CTRL: begin
          s_nxt.ctrl = pwdata & ~(32'h1 << CTRL_CLR_BIT);
        end
        OFF_COUNT: begin
          s_nxt.count = pwdata;
        end
        OFF_STATUS: begin
          if (pwdata[ST_OVF_BIT] && !(do_push && s_r.push != PUSH_IDLE)) begin
            s_nxt.overflow = 1'b0; // new overflow wins over clear
          end
        end
        default: begin
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (rd_acc) begin
      case (paddr)
        OFF_CTRL: s_nxt.prdata = s_r.ctrl;
        OFF_STATUS: s_nxt.prdata = {29'h0, s_r.overflow,
                                    !cap_s.ready, !out_s.valid};
        OFF_COUNT: s_nxt.prdata = s_r.count;
        OFF_HIGH: s_nxt.prdata = s_r.high_level_tick_count;
        OFF_LOW: s_nxt.prdata = s_r.low_level_tick_count;
        OFF_FIFO: s_nxt.prdata = out_s.valid ? out_s.data : 32'h0;
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    if (clr_req) begin
      s_nxt.count = COUNT_RESET;
      s_nxt.run_ticks = '0;
      s_nxt.full_period_count = '0;
      s_nxt.timebase_edge_count = '0;
      s_nxt.first_rise_seen = 1'b0;
      s_nxt.push = PUSH_IDLE;
      if (!(do_push && s_r.push != PUSH_IDLE)) begin
        s_nxt.overflow = 1'b0; // a fresh overflow outlives the clear
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RESET;
      s_r.push <= PUSH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // counter_input_measurement

/* test/counter_input_measurement_props.sv */
/*
  Checker of the register-side handshake of the measurement block.
  Assumes one clock, pclk, and the async active-low presetn.
*/
`timescale 1ns/10ps
module counter_input_measurement_props
  import ci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic edge_input_terminal,
  input wire logic level_input_terminal,
  input wire logic sample_clock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase seen, answer still owed
  sequence taken_s;
    psel && penable && !pready;
  endsequence
  // setup of a count read, then its access phase
  sequence count_rd_s;
    (psel && !penable && !pwrite && paddr == OFF_COUNT) ##1 taken_s;
  endsequence
  AST_ONE_WAIT: assert property (taken_s |=> pready)
    else $error("no answer one cycle after access");
  AST_ANSWER_PULSE: assert property (pready |=> !pready)
    else $error("answer held longer than one cycle");
  AST_ANSWER_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("answer without an access");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error flag outside an answer");
  AST_UNMAPPED: assert property (
    (taken_s and (paddr > OFF_FIFO)) |=> pslverr)
    else $error("unmapped address not refused");
  AST_RO_WRITE: assert property ((taken_s and (pwrite &&
    (paddr == OFF_HIGH || paddr == OFF_LOW || paddr == OFF_FIFO)))
    |=> pslverr)
    else $error("write to read-only place not refused");
  AST_CTRL_OK: assert property (
    (taken_s and (paddr == OFF_CTRL)) |=> !pslverr)
    else $error("control access refused");
  AST_COUNT_RD: assert property (count_rd_s |=> pready && !pslverr)
    else $error("count read not answered cleanly");
  AST_IDLE_QUIET: assert property (!psel [*2] |-> !pready)
    else $error("answer while idle");
endmodule // counter_input_measurement_props

bind counter_input_measurement counter_input_measurement_props props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .edge_input_terminal(edge_input_terminal),
  .level_input_terminal(level_input_terminal),
  .sample_clock(sample_clock)
);

/* test/cim_signal_model.sv */
/*
  Model of the measured signals on the counter terminals.
  Assumes tasks are called just after a rising edge of pclk.
*/
`timescale 1ns/10ps
module cim_signal_model (
  input wire logic pclk,
  output logic edge_input_terminal,
  output logic level_input_terminal,
  output logic sample_clock
);
  // all terminals idle low at start
  initial begin
    edge_input_terminal = 1'b0;
    level_input_terminal = 1'b0;
    sample_clock = 1'b0;
  end
  // n pulses on the counted input
  task automatic edges(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      edge_input_terminal <= 1'b1;
      repeat (hi) @(posedge pclk);
      edge_input_terminal <= 1'b0;
      repeat (lo) @(posedge pclk);
    end
  endtask
  // n full periods on the level input, closed by a final rise
  task automatic periods(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      level_input_terminal <= 1'b1;
      repeat (hi) @(posedge pclk);
      level_input_terminal <= 1'b0;
      repeat (lo) @(posedge pclk);
    end
    level_input_terminal <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  // static level, also used as count direction
  task automatic set_level(input logic v);
    level_input_terminal <= v;
    repeat (3) @(posedge pclk);
  endtask
  // one sample clock period, rising first
  task automatic sample_tick();
    sample_clock <= 1'b1;
    repeat (3) @(posedge pclk);
    sample_clock <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
endmodule // cim_signal_model

/* test/counter_input_measurement_tb.sv */
/*
  Self-checking bench: APB master with an expectation queue, answer
  monitor, and the terminal model. Assumes the checker is bound.
*/
`timescale 1ns/10ps
module counter_input_measurement_tb;
  import ci_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic edge_w;
  logic level_w;
  logic sclk_w;
  logic [33:0] exp_q[$];
  logic [33:0] cur;
  logic [31:0] lfsr_r = 32'h5540fe9f;
  int n_errors = 0;
  int checks_done = 0;
  int a;
  int b;
  int k;

  // 50 MHz
  always #10 pclk = ~pclk;

  counter_input_measurement dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .edge_input_terminal(edge_w),
    .level_input_terminal(level_w), .sample_clock(sclk_w));
  cim_signal_model m (.pclk(pclk), .edge_input_terminal(edge_w),
    .level_input_terminal(level_w), .sample_clock(sclk_w));

  // lfsr keeps every random count at two or more
  function automatic int rnd(input int lim);
    lfsr_r = {lfsr_r[30:0], ^(lfsr_r & 32'h80200003)};
    return 2 + int'(lfsr_r[7:0]) % lim;
  endfunction

  // one transfer; note is {check data, error, data}
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d, input logic [33:0] e);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no count of its own: only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] v);
    apb(1'b0, ad, 32'h0, {2'b10, v});
  endtask
  task automatic skip_rd();
    apb(1'b0, OFF_FIFO, 32'h0, {2'b00, 32'h0});
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, {2'b00, 32'h0});
  endtask
  // clear before each mode so the buffer starts empty
  task automatic mode(input logic [31:0] c);
    wr(OFF_CTRL, 32'h0000_0200);
    wr(OFF_CTRL, c);
  endtask

  // oldest note against each answer
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      cur = exp_q.size() > 0 ? exp_q.pop_front() : 34'h1_0000_0000;
      checks_done++;
      if (pslverr !== cur[32] || (cur[33] && prdata !== cur[31:0])) begin
        n_errors++;
        $display("unexpected at %0t: got %h/%b want %h/%b", $time,
                 prdata, pslverr, cur[31:0], cur[32]);
      end
    end
  end

  task automatic give_verdict();
    if (exp_q.size() != 0) n_errors++;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard, far beyond the several hundred cycles used
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_CTRL, CTRL_RESET);
    rd(OFF_COUNT, COUNT_RESET);
    rd(OFF_STATUS, 32'h0000_0001);
    apb(1'b0, 12'h018, 32'h0, {2'b01, 32'h0});
    apb(1'b1, OFF_HIGH, 32'h5, {2'b01, 32'h0});
    // edge counting: up, down by level, up by level, falling
    mode(32'h0000_0101);
    a = rnd(6);
    m.edges(a, 2, 3);
    rd(OFF_COUNT, 32'(a));
    wr(OFF_CTRL, 32'h0000_0181);
    m.edges(a - 1, 2, 3);
    rd(OFF_COUNT, 32'h0000_0001);
    m.set_level(1'b1);
    m.edges(2, 2, 3);
    rd(OFF_COUNT, 32'h0000_0003);
    wr(OFF_CTRL, 32'h0000_0021);
    m.edges(2, 2, 3);
    rd(OFF_COUNT, 32'h0000_0001);
    wr(OFF_COUNT, 32'hffff_ffff);
    wr(OFF_CTRL, 32'h0000_0101);
    m.edges(1, 2, 3);
    rd(OFF_COUNT, 32'h0000_0000);
    // implicit buffer: four stored, fifth waits, none lost
    mode(32'h0000_0111);
    m.edges(5, 2, 3);
    rd(OFF_STATUS, 32'h0000_0002);
    for (int i = 1; i <= 5; i++) rd(OFF_FIFO, 32'(i));
    rd(OFF_STATUS, 32'h0000_0001);
    rd(OFF_FIFO, 32'h0000_0000);
    // internal sample clock pushes the running count
    mode(32'h0000_0109);
    m.edges(3, 2, 3);
    m.sample_tick();
    m.edges(2, 2, 3);
    m.sample_tick();
    rd(OFF_FIFO, 32'h0000_0003);
    rd(OFF_FIFO, 32'h0000_0005);
    // one-shot pulse, frequency and period share the durations
    for (int j = 1; j < 4; j++) begin
      m.set_level(1'b0);
      mode(32'h0000_0101 | 32'(j * 2));
      a = rnd(6);
      b = rnd(6);
      m.periods(1, a, b);
      rd(OFF_HIGH, 32'(a));
      rd(OFF_LOW, 32'(b));
    end
    // implicit pulse: first word holds an unknown low time
    m.set_level(1'b0);
    mode(32'h0000_0113);
    m.periods(1, a, b);
    skip_rd();
    rd(OFF_FIFO, 32'(a));
    rd(OFF_FIFO, 32'(b));
    // implicit frequency: pair per rise, first pair unknown
    m.set_level(1'b0);
    mode(32'h0000_0115);
    m.periods(1, a, b);
    skip_rd();
    skip_rd();
    rd(OFF_FIFO, 32'(a));
    rd(OFF_FIFO, 32'(b));
    // averaging: periods and timebase edges between sample rises
    for (int j = 2; j < 4; j++) begin
      m.set_level(1'b0);
      mode(32'h0000_0109 | 32'(j * 2));
      m.sample_tick();
      k = rnd(3);
      m.periods(k, a, b);
      m.sample_tick();
      skip_rd();
      skip_rd();
      rd(OFF_FIFO, 32'(k));
      rd(OFF_FIFO, 32'(k * (a + b)));
    end
    // internal pulse on falling sample edge: last high time stored
    m.set_level(1'b0);
    mode(32'h0000_014b);
    m.set_level(1'b1);
    m.set_level(1'b0);
    m.sample_tick();
    rd(OFF_FIFO, 32'h0000_0003);
    rd(OFF_STATUS, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    give_verdict();
  end
endmodule // counter_input_measurement_tb
